// [rtl/nvsq_cfg.svh]
// Timing constants and rule summary for the nonvolatile save and restore sequencer
// What this block does
// - Skip triggered save when no write pending
// - Keep access open one grace time, except after supply loss
// - Ignore memory requests while busy or low
// - Power-on restore done within variant time
// - Act on sequence command within latency
// - Save 8 ms, restore 600 us lockout
// - Access off while store-busy pin low, except in the grace time
// - Ready within 5 us after pin high
// - Enter sleep within 8 ms
// - Wake within variant time
// - Standby within 100 us after deselect; the timer starts only while not busy
`ifndef NVSQ_CFG_SVH
`define NVSQ_CFG_SVH

`define NVSQ_CLK_NS 100
`define NVSQ_ACCESS_GRACE_NS 25
`define NVSQ_SAVE_PULSE_MIN_NS 15
`define NVSQ_SEQ_CMD_LATENCY_US 500
`define NVSQ_SAVE_TIME_MS 8
`define NVSQ_RESTORE_TIME_US 600
`define NVSQ_PIN_READY_US 5
`define NVSQ_SLEEP_ENTRY_MS 8
`define NVSQ_STANDBY_ENTRY_US 100
`define NVSQ_POR_RESTORE_LOW_MS 40
`define NVSQ_POR_RESTORE_STD_MS 20
`define NVSQ_WAKE_LOW_MS 40
`define NVSQ_WAKE_STD_MS 20

// Longest times round down, none below one cycle
`define NVSQ_GRACE_CYC ((`NVSQ_ACCESS_GRACE_NS / `NVSQ_CLK_NS) > 0 ? \
    (`NVSQ_ACCESS_GRACE_NS / `NVSQ_CLK_NS) : 1)
`define NVSQ_SEQ_CMD_CYC ((`NVSQ_SEQ_CMD_LATENCY_US * 1000) / `NVSQ_CLK_NS)
`define NVSQ_SAVE_CYC ((`NVSQ_SAVE_TIME_MS * 1000000) / `NVSQ_CLK_NS)
`define NVSQ_RESTORE_CYC ((`NVSQ_RESTORE_TIME_US * 1000) / `NVSQ_CLK_NS)
`define NVSQ_PIN_READY_CYC ((`NVSQ_PIN_READY_US * 1000) / `NVSQ_CLK_NS)
`define NVSQ_SLEEP_CYC ((`NVSQ_SLEEP_ENTRY_MS * 1000000) / `NVSQ_CLK_NS)
`define NVSQ_STANDBY_CYC ((`NVSQ_STANDBY_ENTRY_US * 1000) / `NVSQ_CLK_NS)
`define NVSQ_POR_LOW_CYC ((`NVSQ_POR_RESTORE_LOW_MS * 1000000) / `NVSQ_CLK_NS)
`define NVSQ_POR_STD_CYC ((`NVSQ_POR_RESTORE_STD_MS * 1000000) / `NVSQ_CLK_NS)
`define NVSQ_WAKE_LOW_CYC ((`NVSQ_WAKE_LOW_MS * 1000000) / `NVSQ_CLK_NS)
`define NVSQ_WAKE_STD_CYC ((`NVSQ_WAKE_STD_MS * 1000000) / `NVSQ_CLK_NS)

`endif

// [rtl/nvsq_pkg.sv]
// Types shared by the sequencer files
`default_nettype none
package nvsq_pkg;
    typedef enum logic [2:0] {
        NVSQ_CMD_NONE,
        NVSQ_CMD_SAVE,
        NVSQ_CMD_RESTORE,
        NVSQ_CMD_AUTO_EN,
        NVSQ_CMD_AUTO_DIS,
        NVSQ_CMD_SLEEP
    } nvsq_cmd_e;

    typedef struct packed {
        logic valid;
        nvsq_cmd_e cmd;
    } nvsq_cmd_s;

    typedef struct packed {
        logic rd;
        logic wr;
    } nvsq_mem_req_s;

    typedef struct packed {
        logic access_en;
        logic busy;
        logic sleeping;
        logic standby;
        logic auto_save_en;
        logic write_pending;
    } nvsq_status_s;
endpackage
`default_nettype wire

// [rtl/nvsq_sequencer.sv]
// Nonvolatile save and restore sequencer top
`timescale 1ns/1ns
`default_nettype none
`include "nvsq_cfg.svh"
module nvsq_sequencer #(
    parameter bit LOW_VOLT_VARIANT = 1'b0,
    parameter int SAVE_CYC = `NVSQ_SAVE_CYC,
    parameter int RESTORE_CYC = `NVSQ_RESTORE_CYC,
    parameter int SEQ_CMD_CYC = `NVSQ_SEQ_CMD_CYC,
    parameter int PIN_READY_CYC = `NVSQ_PIN_READY_CYC,
    parameter int SLEEP_CYC = `NVSQ_SLEEP_CYC,
    parameter int STANDBY_CYC = `NVSQ_STANDBY_CYC,
    parameter int POR_CYC = LOW_VOLT_VARIANT ? `NVSQ_POR_LOW_CYC : `NVSQ_POR_STD_CYC,
    parameter int WAKE_CYC = LOW_VOLT_VARIANT ? `NVSQ_WAKE_LOW_CYC : `NVSQ_WAKE_STD_CYC
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic supply_ok,
    input wire logic cs_n,
    input wire nvsq_pkg::nvsq_cmd_s seq_cmd,
    input wire logic wake_req,
    input wire nvsq_pkg::nvsq_mem_req_s mem_req,
    input wire logic hardware_store_busy_pin_i,
    output logic hardware_store_busy_pin_o,
    output logic hardware_store_busy_pin_oe,
    output nvsq_pkg::nvsq_mem_req_s mem_grant,
    output logic nv_save_start,
    output logic nv_restore_start,
    output nvsq_pkg::nvsq_status_s status
);
    import nvsq_pkg::*;

    localparam int TW = 24;
    localparam int GRACE_CYC = `NVSQ_GRACE_CYC;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        NVSQ_ST_POR,
        NVSQ_ST_IDLE,
        NVSQ_ST_CMD_WAIT,
        NVSQ_ST_GRACE,
        NVSQ_ST_SAVE,
        NVSQ_ST_RESTORE,
        NVSQ_ST_PIN_HELD,
        NVSQ_ST_PIN_READY,
        NVSQ_ST_SLEEP_ENTRY,
        NVSQ_ST_SLEEP,
        NVSQ_ST_WAKE,
        NVSQ_ST_LOW
    } nvsq_state_e;

    typedef struct packed {
        nvsq_state_e st;
        nvsq_cmd_e cmd;
        logic from_pin;
        logic from_power;
        logic write_pending;
        logic auto_save_en;
        logic standby;
        logic save_start;
        logic restore_start;
        logic [3:0] grace;
        logic supply_q;
    } nvsq_state_s;

    nvsq_state_s s_q;
    nvsq_state_s s_d;

    logic tmr_load;
    logic [TW-1:0] tmr_count;
    logic tmr_done;
    logic tmr_run;
    logic sb_load;
    logic sb_stop;
    logic sb_done;
    logic sb_run_w;
    logic pin_low;
    logic op_busy;

    function automatic logic [TW-1:0] cyc(input int n);
        cyc = (n < 1) ? TW'(1) : TW'(n);
    endfunction

    assign pin_low = !hardware_store_busy_pin_i;

    // ------------------------------------------------------------
    // Timers
    // ------------------------------------------------------------
    nvsq_timer #(.W(TW)) u_op_tmr (
        .clk(clk),
        .nrst(nrst),
        .en(ce),
        .load(tmr_load),
        .count(tmr_count),
        .stop(1'b0),
        .running(tmr_run),
        .done(tmr_done)
    );

    assign sb_load = !s_q.standby && cs_n && !op_busy && !sb_run_w;
    assign sb_stop = !cs_n;
    nvsq_timer #(.W(TW)) u_sb_tmr (
        .clk(clk),
        .nrst(nrst),
        .en(ce),
        .load(sb_load),
        .count(cyc(STANDBY_CYC)),
        .stop(sb_stop),
        .running(sb_run_w),
        .done(sb_done)
    );

    // ------------------------------------------------------------
    // Sequencing
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.save_start = 1'b0;
        s_d.restore_start = 1'b0;
        s_d.supply_q = supply_ok;
        tmr_load = 1'b0;
        tmr_count = '0;
        if (mem_grant.wr) begin
            s_d.write_pending = 1'b1;
        end
        if (!cs_n) begin
            s_d.standby = 1'b0;
        end else if (sb_done) begin
            s_d.standby = 1'b1;
        end
        unique case (s_q.st)
            NVSQ_ST_POR: begin
                if (supply_ok && !s_q.supply_q) begin
                    tmr_load = 1'b1;
                    tmr_count = cyc(POR_CYC);
                    s_d.restore_start = 1'b1;
                end else if (tmr_done) begin
                    s_d.write_pending = 1'b0;
                    s_d.st = NVSQ_ST_IDLE;
                end
            end
            NVSQ_ST_IDLE: begin
                if (!supply_ok) begin
                    s_d.st = s_q.write_pending && s_q.auto_save_en ? NVSQ_ST_GRACE : NVSQ_ST_LOW;
                    s_d.cmd = NVSQ_CMD_SAVE;
                    s_d.from_power = 1'b1;
                    s_d.grace = 4'(GRACE_CYC);
                end else if (pin_low) begin
                    s_d.st = s_q.write_pending ? NVSQ_ST_GRACE : NVSQ_ST_PIN_HELD;
                    s_d.cmd = NVSQ_CMD_SAVE;
                    s_d.from_pin = 1'b1;
                    s_d.grace = 4'(GRACE_CYC);
                end else if (seq_cmd.valid && seq_cmd.cmd != NVSQ_CMD_NONE) begin
                    s_d.cmd = seq_cmd.cmd;
                    s_d.st = NVSQ_ST_CMD_WAIT;
                    tmr_load = 1'b1;
                    tmr_count = cyc(SEQ_CMD_CYC);
                end
            end
            NVSQ_ST_CMD_WAIT: begin
                if (tmr_done) begin
                    if (s_q.cmd == NVSQ_CMD_SLEEP) begin
                        s_d.st = NVSQ_ST_SLEEP_ENTRY;
                        tmr_load = 1'b1;
                        tmr_count = cyc(SLEEP_CYC);
                    end else begin
                        s_d.st = NVSQ_ST_GRACE;
                        s_d.grace = 4'(GRACE_CYC);
                    end
                end
            end
            NVSQ_ST_GRACE: begin
                if (s_q.grace <= 4'h1) begin
                    unique case (s_q.cmd)
                        NVSQ_CMD_SAVE: begin
                            s_d.st = NVSQ_ST_SAVE;
                            s_d.save_start = 1'b1;
                            tmr_load = 1'b1;
                            tmr_count = cyc(SAVE_CYC);
                        end
                        NVSQ_CMD_RESTORE: begin
                            s_d.st = NVSQ_ST_RESTORE;
                            s_d.restore_start = 1'b1;
                            tmr_load = 1'b1;
                            tmr_count = cyc(RESTORE_CYC);
                        end
                        NVSQ_CMD_AUTO_EN: begin
                            s_d.auto_save_en = 1'b1;
                            s_d.st = NVSQ_ST_IDLE;
                        end
                        default: begin
                            s_d.auto_save_en = 1'b0;
                            s_d.st = NVSQ_ST_IDLE;
                        end
                    endcase
                end else begin
                    s_d.grace = s_q.grace - 4'h1;
                end
            end
            NVSQ_ST_SAVE, NVSQ_ST_RESTORE: begin
                if (tmr_done) begin
                    s_d.write_pending = mem_grant.wr;
                    s_d.st = s_q.from_power ? NVSQ_ST_LOW :
                             s_q.from_pin ? NVSQ_ST_PIN_HELD : NVSQ_ST_IDLE;
                end
            end
            NVSQ_ST_PIN_HELD: begin
                if (!pin_low) begin
                    s_d.st = NVSQ_ST_PIN_READY;
                    tmr_load = 1'b1;
                    tmr_count = cyc(PIN_READY_CYC);
                end
            end
            NVSQ_ST_PIN_READY: begin
                if (tmr_done || !tmr_run) begin
                    s_d.from_pin = 1'b0;
                    s_d.st = NVSQ_ST_IDLE;
                end
            end
            NVSQ_ST_SLEEP_ENTRY: begin
                if (tmr_done) begin
                    s_d.st = NVSQ_ST_SLEEP;
                end
            end
            NVSQ_ST_SLEEP: begin
                if (wake_req) begin
                    s_d.st = NVSQ_ST_WAKE;
                    tmr_load = 1'b1;
                    tmr_count = cyc(WAKE_CYC);
                end
            end
            NVSQ_ST_WAKE: begin
                if (tmr_done) begin
                    s_d.st = NVSQ_ST_IDLE;
                end
            end
            NVSQ_ST_LOW: begin
                s_d.from_power = 1'b0;
                // Pin origin must not outlive a power cycle
                s_d.from_pin = 1'b0;
                if (supply_ok) begin
                    s_d.st = NVSQ_ST_POR;
                    s_d.supply_q = 1'b0;
                end
            end
        endcase
        // Supply loss overrides every state except idle, grace, save and low
        if (!supply_ok && s_q.st != NVSQ_ST_IDLE && s_q.st != NVSQ_ST_SAVE
            && s_q.st != NVSQ_ST_GRACE && s_q.st != NVSQ_ST_LOW) begin
            s_d.st = NVSQ_ST_LOW;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_q <= '{st: NVSQ_ST_POR, cmd: NVSQ_CMD_NONE, default: '0};
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Access gating
    // ------------------------------------------------------------
    assign op_busy = !(s_q.st == NVSQ_ST_IDLE || s_q.st == NVSQ_ST_CMD_WAIT
                       || s_q.st == NVSQ_ST_GRACE);

    always_comb begin
        if (op_busy || !supply_ok || (pin_low && s_q.st != NVSQ_ST_GRACE)) begin
            mem_grant = '0;
        end else begin
            mem_grant = mem_req;
        end
    end

    // Pin driven low while the save runs
    assign hardware_store_busy_pin_o = 1'b0;
    assign hardware_store_busy_pin_oe = (s_q.st == NVSQ_ST_SAVE);
    assign nv_save_start = s_q.save_start;
    assign nv_restore_start = s_q.restore_start;

    always_comb begin
        status.access_en = !op_busy && supply_ok;
        status.busy = op_busy;
        status.sleeping = (s_q.st == NVSQ_ST_SLEEP);
        status.standby = s_q.standby;
        status.auto_save_en = s_q.auto_save_en;
        status.write_pending = s_q.write_pending;
    end
endmodule // nvsq_sequencer
`default_nettype wire

// [rtl/nvsq_timer.sv]
// Loadable down counter with a done pulse
`timescale 1ns/1ns
`default_nettype none
module nvsq_timer #(
    parameter int W = 24
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic en,
    input wire logic load,
    input wire logic [W-1:0] count,
    input wire logic stop,
    output logic running,
    output logic done
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic run;
        logic done;
    } nvsq_tmr_s;

    nvsq_tmr_s s_q;
    nvsq_tmr_s s_d;

    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        if (stop) begin
            s_d.run = 1'b0;
        end else if (load) begin
            s_d.cnt = count;
            s_d.run = 1'b1;
        end else if (s_q.run) begin
            if (s_q.cnt <= W'(1)) begin
                s_d.run = 1'b0;
                s_d.done = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt - W'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_q <= '0;
        end else if (en) begin
            s_q <= s_d;
        end
    end

    assign running = s_q.run;
    assign done = s_q.done;
endmodule // nvsq_timer
`default_nettype wire

// [testbench/nvsq_host_model.sv]
// Host side model: chip select, sequence commands and memory requests
`timescale 1ns/1ns
`default_nettype none
module nvsq_host_model
import nvsq_pkg::*;
(
    input wire logic clk,
    input wire nvsq_pkg::nvsq_mem_req_s mem_grant,
    output logic cs_n,
    output nvsq_pkg::nvsq_cmd_s seq_cmd,
    output nvsq_pkg::nvsq_mem_req_s mem_req
);
    initial begin
        cs_n = 1'b1;
        seq_cmd = '0;
        mem_req = '0;
    end
    // Code is inverted on release so no stale command lingers
    task automatic cmd(input nvsq_cmd_e c);
        @(negedge clk);
        cs_n = 1'b0;
        seq_cmd = '{1'b1, c};
        @(negedge clk);
        cs_n = 1'b1;
        seq_cmd = '{1'b0, nvsq_cmd_e'(~c)};
    endtask
    task automatic acc(input nvsq_mem_req_s r, output nvsq_mem_req_s g);
        @(negedge clk);
        cs_n = 1'b0;
        mem_req = r;
        #1 g = mem_grant;
        @(negedge clk);
        cs_n = 1'b1;
        mem_req = '0;
    endtask
endmodule // nvsq_host_model
`default_nettype wire

// [testbench/nvsq_sequencer_props.sv]
// Port checker for the nonvolatile save and restore sequencer
`timescale 1ns/1ns
`default_nettype none
module nvsq_sequencer_props
import nvsq_pkg::*;
#(
    parameter int SEQ_CMD_CYC = 4,
    parameter int SLEEP_CYC = 6,
    parameter int STANDBY_CYC = 7,
    parameter int POR_CYC = 10,
    parameter int WAKE_CYC = 9,
    parameter int PIN_READY_CYC = 5
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic supply_ok,
    input wire logic cs_n,
    input wire nvsq_pkg::nvsq_cmd_s seq_cmd,
    input wire logic wake_req,
    input wire logic hardware_store_busy_pin_i,
    input wire logic hardware_store_busy_pin_oe,
    input wire nvsq_pkg::nvsq_mem_req_s mem_grant,
    input wire logic nv_save_start,
    input wire nvsq_pkg::nvsq_status_s status
);
    localparam int CMD_HI = SEQ_CMD_CYC + 4;
    localparam int SLP_HI = SEQ_CMD_CYC + SLEEP_CYC + 5;
    localparam int WAK_HI = WAKE_CYC + 3;
    localparam int POR_HI = POR_CYC + 4;
    localparam int RDY_HI = PIN_READY_CYC + 3;
    localparam logic [7:0] SB_HI = 8'(STANDBY_CYC + 2);
    logic idle;
    logic [7:0] sb_q;
    assign idle = seq_cmd.valid & ~status.busy & ~status.sleeping & supply_ok
        & hardware_store_busy_pin_i;
    // ----------------------------
    // Deselected idle cycle count
    // ----------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sb_q <= 8'h00;
        end else if (cs_n && !status.busy && !status.sleeping) begin
            sb_q <= (sb_q < SB_HI) ? sb_q + 8'h01 : sb_q;
        end else begin
            sb_q <= 8'h00;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    property p_low; (!supply_ok) [*3] |-> mem_grant == '0; endproperty
    a_low: assert property (p_low) else $error("grant with supply low");
    property p_pin; (!hardware_store_busy_pin_i) [*3] |-> mem_grant == '0; endproperty
    a_pin: assert property (p_pin) else $error("grant with pin low");
    property p_skip;
        $fell(hardware_store_busy_pin_i) && !status.write_pending && !status.busy
            |-> (!nv_save_start) [*6];
    endproperty
    a_skip: assert property (p_skip) else $error("save without write");
    property p_wr; mem_grant.wr |=> status.write_pending; endproperty
    a_wr: assert property (p_wr) else $error("write not flagged");
    property p_cmd; idle && seq_cmd.cmd == NVSQ_CMD_SAVE |-> ##[1:CMD_HI] nv_save_start;
    endproperty
    a_cmd: assert property (p_cmd) else $error("save command late");
    property p_save; nv_save_start |-> (status.busy) [*8]; endproperty
    a_save: assert property (p_save) else $error("save ended early");
    property p_slp; idle && seq_cmd.cmd == NVSQ_CMD_SLEEP |-> ##[1:SLP_HI] status.sleeping;
    endproperty
    a_slp: assert property (p_slp) else $error("sleep late");
    property p_wak;
        status.sleeping && wake_req |-> ##[1:WAK_HI] !status.sleeping && !status.busy;
    endproperty
    a_wak: assert property (p_wak) else $error("wake late");
    property p_por; $rose(supply_ok) |-> ##[1:POR_HI] !status.busy; endproperty
    a_por: assert property (p_por) else $error("restore late");
    property p_sb; sb_q == SB_HI |-> status.standby; endproperty
    a_sb: assert property (p_sb) else $error("standby late");
    property p_rdy;
        $rose(hardware_store_busy_pin_i) && !hardware_store_busy_pin_oe && status.busy
            && supply_ok |-> ##[1:RDY_HI] !status.busy;
    endproperty
    a_rdy: assert property (p_rdy) else $error("not ready after pin");
endmodule // nvsq_sequencer_props
`default_nettype wire

// [testbench/nvsq_sequencer_tb_top.sv]
// Self-checking bench for the nonvolatile save and restore sequencer
`timescale 1ns/1ns
`default_nettype none
module nvsq_sequencer_tb_top;
    import nvsq_pkg::*;
    localparam int SAVE_CYC = 8;
    localparam int RESTORE_CYC = 6;
    localparam int SEQ_CMD_CYC = 4;
    localparam int PIN_READY_CYC = 5;
    localparam int SLEEP_CYC = 6;
    localparam int STANDBY_CYC = 7;
    localparam int POR_CYC = 10;
    localparam int WAKE_CYC = 9;
    logic clk, nrst, supply_ok, wake_req, pin_drv, cs_n, pin_o, pin_oe, save_st, rcl_st;
    wire logic pin_w;
    nvsq_cmd_s seq_cmd;
    nvsq_mem_req_s mem_req, mem_grant, g;
    nvsq_status_s status;
    int n_errors, tests_run, cyc;
    // Open-drain pin with pull-up
    assign pin_w = pin_drv & ~(pin_oe & ~pin_o);
    always #50 clk = ~clk;
    nvsq_host_model host_u (.clk(clk), .mem_grant(mem_grant), .cs_n(cs_n),
        .seq_cmd(seq_cmd), .mem_req(mem_req));
    nvsq_sequencer #(.SAVE_CYC(SAVE_CYC), .RESTORE_CYC(RESTORE_CYC),
        .SEQ_CMD_CYC(SEQ_CMD_CYC), .PIN_READY_CYC(PIN_READY_CYC), .SLEEP_CYC(SLEEP_CYC),
        .STANDBY_CYC(STANDBY_CYC), .POR_CYC(POR_CYC), .WAKE_CYC(WAKE_CYC)) dut_u (
        .clk(clk), .nrst(nrst), .ce(1'b1), .supply_ok(supply_ok), .cs_n(cs_n),
        .seq_cmd(seq_cmd), .wake_req(wake_req), .mem_req(mem_req),
        .hardware_store_busy_pin_i(pin_w), .hardware_store_busy_pin_o(pin_o),
        .hardware_store_busy_pin_oe(pin_oe), .mem_grant(mem_grant),
        .nv_save_start(save_st), .nv_restore_start(rcl_st), .status(status));
    // ---------------------
    // Checks and waits
    // ---------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic sig(input int s);
        case (s)
            0: return save_st;
            1: return rcl_st;
            2: return !status.busy && !status.sleeping;
            3: return status.sleeping;
            default: return status.standby;
        endcase
    endfunction
    task automatic wt(input int s, input int lim);
        for (int i = 0; i < lim && sig(s) !== 1'b1; i++) @(negedge clk);
        chk(8'(sig(s)), 8'h01);
    endtask
    task automatic test_done();
        $display("Checks %0d, errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic t_por();
        host_u.acc('{1'b0, 1'b1}, g);
        chk(8'(g), 8'h00);
        wt(2, POR_CYC + 4);
        chk(8'(status.write_pending), 8'h00);
    endtask
    task automatic t_nv();
        for (int k = 0; k < 2; k++) begin
            host_u.acc('{1'b1, 1'b1}, g);
            chk(8'(g), 8'h03);
            chk(8'(status.write_pending), 8'h01);
            host_u.cmd(k == 0 ? NVSQ_CMD_SAVE : NVSQ_CMD_RESTORE);
            wt(k, SEQ_CMD_CYC + 4);
            chk(8'({pin_oe, pin_o, status.access_en}), k == 0 ? 8'h04 : 8'h00);
            host_u.acc('{1'b1, 1'b1}, g);
            chk(8'(g), 8'h00);
            wt(2, (k == 0 ? SAVE_CYC : RESTORE_CYC) + 2);
            chk(8'(status.write_pending), 8'h00);
        end
    endtask
    task automatic t_auto();
        nvsq_cmd_e ac[3] = '{NVSQ_CMD_AUTO_EN, NVSQ_CMD_AUTO_DIS, NVSQ_CMD_AUTO_EN};
        foreach (ac[k]) begin
            host_u.cmd(ac[k]);
            repeat (SEQ_CMD_CYC + 4) @(negedge clk);
            chk(8'(status.auto_save_en), 8'(k != 1));
        end
        host_u.acc('{1'b0, 1'b1}, g);
        supply_ok = 1'b0;
        wt(0, 4);
        host_u.acc('{1'b1, 1'b0}, g);
        chk(8'(g), 8'h00);
        repeat (SAVE_CYC + 4) @(negedge clk);
        supply_ok = 1'b1;
        wt(2, POR_CYC + 4);
    endtask
    task automatic t_pin();
        logic seen;
        seen = 1'b0;
        pin_drv = 1'b0;
        repeat (6) begin
            @(negedge clk);
            seen |= save_st;
        end
        host_u.acc('{1'b1, 1'b0}, g);
        chk(8'(g), 8'h00);
        pin_drv = 1'b1;
        wt(2, PIN_READY_CYC + 3);
        chk(8'(seen), 8'h00);
        host_u.acc('{1'b0, 1'b1}, g);
        pin_drv = 1'b0;
        wt(0, 4);
        host_u.acc('{1'b1, 1'b0}, g);
        chk(8'(g), 8'h00);
        pin_drv = 1'b1;
        wt(2, SAVE_CYC + PIN_READY_CYC + 4);
        chk(8'(status.write_pending), 8'h00);
    endtask
    task automatic t_sleep();
        host_u.cmd(NVSQ_CMD_SLEEP);
        wt(3, SEQ_CMD_CYC + SLEEP_CYC + 5);
        wake_req = 1'b1;
        wt(2, WAKE_CYC + 3);
        wake_req = 1'b0;
        wt(4, STANDBY_CYC + 3);
        host_u.acc('{1'b1, 1'b0}, g);
        chk(8'(status.standby), 8'h00);
        wt(4, STANDBY_CYC + 3);
    endtask
    initial begin
        clk = 1'b0;
        nrst = 1'b0;
        supply_ok = 1'b1;
        wake_req = 1'b0;
        pin_drv = 1'b1;
        n_errors = 0;
        tests_run = 0;
        repeat (12) @(negedge clk);
        nrst = 1'b1;
        t_por();
        t_nv();
        t_auto();
        t_pin();
        t_sleep();
        test_done();
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_errors++;
            test_done();
        end
    end
endmodule // nvsq_sequencer_tb_top
bind nvsq_sequencer nvsq_sequencer_props #(.SEQ_CMD_CYC(SEQ_CMD_CYC),
    .SLEEP_CYC(SLEEP_CYC), .STANDBY_CYC(STANDBY_CYC), .POR_CYC(POR_CYC),
    .WAKE_CYC(WAKE_CYC), .PIN_READY_CYC(PIN_READY_CYC)) props_u (
    .clk(clk),
    .nrst(nrst),
    .supply_ok(supply_ok),
    .cs_n(cs_n),
    .seq_cmd(seq_cmd),
    .wake_req(wake_req),
    .hardware_store_busy_pin_i(hardware_store_busy_pin_i),
    .hardware_store_busy_pin_oe(hardware_store_busy_pin_oe),
    .mem_grant(mem_grant),
    .nv_save_start(nv_save_start),
    .status(status));
`default_nettype wire
